//--- design/host_strobe_sync.sv
// Purpose: two-flop synchroniser with edge detect for host strobes
// Assumes: all inputs idle high
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
`include "ide_host_signal_map.svh"
module host_strobe_sync
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_resetn,
  input  wire ide_host_signal_pkg::sync_t  i_async,
  output ide_host_signal_pkg::sync_t       o_level,
  output ide_host_signal_pkg::sync_t       o_rise,
  output ide_host_signal_pkg::sync_t       o_fall
);
  import ide_host_signal_pkg::*;
  sync_t meta_reg;
  sync_t level_reg;
  sync_t prev_reg;

  // three stages: meta, level, previous level
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      meta_reg  <= `SYNC_IDLE;
      level_reg <= `SYNC_IDLE;
      prev_reg  <= `SYNC_IDLE;
    end
    else
    begin
      meta_reg  <= i_async;
      level_reg <= meta_reg;
      prev_reg  <= level_reg;
    end
  end

  // edges from settled stages only
  assign o_level = level_reg;
  assign o_rise  = level_reg & ~prev_reg;
  assign o_fall  = ~level_reg & prev_reg;
endmodule : host_strobe_sync

//--- design/ide_device_host_signal_logic.sv
// Purpose: drive-side logic of the host connector signals
// Assumes: address decode and register file sit outside
// Notes:   strobe edges pass a two-flop synchroniser; read capture and bus and ready enables use raw strobes
// Behaviour
// - drive selected register data on the bus; read completes at strobe rise
// - pull ready low while an access cannot yet be answered
// - release ready to high impedance when not stretching
// - cable select low gives drive 0, high gives drive 1
// - keep DMA request up while more data remains
// - interrupt pin driven when selected and unmasked; high only if pending
// - masked or unselected interrupt pin floats
// - reset, soft reset, command write or status read clear interrupt
// - each PIO data block start raises the interrupt, except a suppressed first block
// - four write-type commands skip the first block interrupt
// - wide-port signal pulled low on data port access when word ready
// - narrow transfers use low byte; wide ones all sixteen lines
// - raise DMA request when ready; strobe type picks direction
// - write data captured at write strobe rise
`timescale 1ns/1ps
`include "ide_host_signal_map.svh"
module ide_device_host_signal_logic
(
  input  wire logic                             i_mclk,
  input  wire logic                             i_resetn,
  // host connector pins
  input  wire logic                             i_host_reset_n,
  input  wire logic                             i_dior_n,
  input  wire logic                             i_diow_n,
  input  wire logic                             i_dma_grant_n,
  input  wire logic                             i_cable_sel,
  input  wire ide_host_signal_pkg::dd_t         i_dd,
  output ide_host_signal_pkg::dd_t              o_dd,
  output logic                                  o_dd_oe,
  output logic                                  o_iordy_out,
  output logic                                  o_iordy_oe,
  output logic                                  o_iocs16_out,
  output logic                                  o_iocs16_oe,
  output logic                                  o_intrq_out,
  output logic                                  o_intrq_oe,
  output logic                                  o_dmarq,
  // decoded address of the current access
  input  wire logic                             i_cs_active,
  input  wire logic                             i_addr_data,
  input  wire logic                             i_addr_status,
  input  wire logic                             i_addr_command,
  // drive-side status and control
  input  wire ide_host_signal_pkg::dd_t         i_rd_data,
  input  wire logic                             i_busy,
  input  wire logic                             i_word_ready,
  input  wire logic                             i_dma_ready,
  input  wire logic                             i_dev_bit,
  input  wire logic                             i_nien,
  input  wire logic                             i_srst,
  input  wire logic                             i_irq_event,
  input  wire logic                             i_block_start,
  input  wire logic                             i_first_block,
  input  wire ide_host_signal_pkg::cmd_class_e  i_cmd_class,
  output logic                                  o_drive_num,
  output logic                                  o_selected,
  output logic                                  o_rd_done,
  output logic                                  o_wr_done,
  output ide_host_signal_pkg::dd_t              o_wr_data,
  output logic                                  o_wr_wide,
  output logic                                  o_dma_rd_done,
  output logic                                  o_dma_wr_done,
  output logic                                  o_host_reset,
  output logic                                  o_irq_pending
);
  import ide_host_signal_pkg::*;

  // keep the low byte always, high byte only on a wide transfer
  function automatic dd_t lane_mask(input dd_t data, input logic wide);
    lane_mask = wide ? data : {`DD_HI_ZERO, data[`DD_LO_W-1:0]};
  endfunction : lane_mask

  sync_t raw_pins;
  sync_t lvl;
  sync_t rise;
  dd_t   dd_meta_reg;
  dd_t   dd_pipe_reg;
  dd_t   wr_hold_reg;
  dd_t   wr_data_reg;
  dd_t   rd_out_reg;
  logic  wide_now;
  logic  rd_wide_reg;
  logic  wr_wide_reg;
  logic  wr_wide_hold_reg;
  logic  rd_done_reg;
  logic  wr_done_reg;
  logic  dma_rd_reg;
  logic  dma_wr_reg;
  logic  dmarq_reg;
  logic  drive_reg;
  logic  strap_done_reg;
  logic  grant;
  logic  host_reset;
  logic  access;
  logic  irq_clear;
  logic  irq_pending;

  // bundle the asynchronous pins for the synchroniser
  always_comb
  begin
    raw_pins              = `SYNC_IDLE;
    raw_pins[`SYNC_DIOR]  = i_dior_n;
    raw_pins[`SYNC_DIOW]  = i_diow_n;
    raw_pins[`SYNC_GRANT] = i_dma_grant_n;
    raw_pins[`SYNC_HRST]  = i_host_reset_n;
  end

  host_strobe_sync u_sync
  (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (raw_pins),
    .o_level  (lvl),
    .o_rise   (rise),
    .o_fall   ()
  );

  assign grant      = !lvl[`SYNC_GRANT];
  assign host_reset = !lvl[`SYNC_HRST];
  assign wide_now   = i_addr_data && i_word_ready;

  // data bus pipeline aligned with the strobe synchroniser
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      dd_meta_reg <= `DD_ZERO;
      dd_pipe_reg <= `DD_ZERO;
    end
    else
    begin
      dd_meta_reg <= i_dd;
      dd_pipe_reg <= dd_meta_reg;
    end
  end

  // hold the last word seen while the write strobe was low
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      wr_hold_reg      <= `DD_ZERO;
      wr_wide_hold_reg <= `BIT_CLR;
    end
    else if (!lvl[`SYNC_DIOW])
    begin
      wr_hold_reg      <= dd_pipe_reg;
      wr_wide_hold_reg <= wide_now;
    end
  end

  // write completes on the synchronised strobe rise
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      wr_data_reg <= `DD_ZERO;
      wr_wide_reg <= `BIT_CLR;
      wr_done_reg <= `BIT_CLR;
      dma_wr_reg  <= `BIT_CLR;
    end
    else
    begin
      wr_done_reg <= rise[`SYNC_DIOW] && !grant;
      dma_wr_reg  <= rise[`SYNC_DIOW] && grant;
      if (rise[`SYNC_DIOW])
      begin
        wr_data_reg <= lane_mask(wr_hold_reg, wr_wide_hold_reg);
        wr_wide_reg <= wr_wide_hold_reg;
      end
    end
  end

  // read data follows the register while the strobe is low
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      rd_out_reg  <= `DD_ZERO;
      rd_wide_reg <= `BIT_CLR;
    end
    else if (!i_dior_n)
    begin
      rd_out_reg  <= lane_mask(i_rd_data, wide_now);
      rd_wide_reg <= wide_now;
    end
  end

  // read completes on the synchronised strobe rise
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      rd_done_reg <= `BIT_CLR;
      dma_rd_reg  <= `BIT_CLR;
    end
    else
    begin
      rd_done_reg <= rise[`SYNC_DIOR] && !grant;
      dma_rd_reg  <= rise[`SYNC_DIOR] && grant;
    end
  end

  // bus driven for the whole read strobe so it holds to the rise
  assign o_dd_oe = !i_dior_n && (i_cs_active || grant);
  assign o_dd    = rd_out_reg;

  // stretch an access the drive cannot answer yet
  assign access      = i_cs_active && (!i_dior_n || !i_diow_n);
  assign o_iordy_oe  = access && i_busy;
  assign o_iordy_out = `PIN_LOW;

  // wide-port indication, open collector
  assign o_iocs16_oe  = i_cs_active && wide_now;
  assign o_iocs16_out = `PIN_LOW;

  // request level follows data readiness
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      dmarq_reg <= `BIT_CLR;
    else
      dmarq_reg <= i_dma_ready;
  end

  // cable select strap caught once after reset release
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
    begin
      drive_reg      <= `DRIVE_0;
      strap_done_reg <= `BIT_CLR;
    end
    else if (!strap_done_reg)
    begin
      drive_reg      <= i_cable_sel;
      strap_done_reg <= `BIT_SET;
    end
  end

  // interrupt clears from host and register events
  assign irq_clear = host_reset || i_srst ||
                     (wr_done_reg && i_addr_command) ||
                     (rd_done_reg && i_addr_status);

  intrq_ctrl u_intrq
  (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_irq_event   (i_irq_event),
    .i_block_start (i_block_start),
    .i_first_block (i_first_block),
    .i_cmd_class   (i_cmd_class),
    .i_clear       (irq_clear),
    .i_selected    (o_selected),
    .i_nien        (i_nien),
    .o_pending     (irq_pending),
    .o_intrq_out   (o_intrq_out),
    .o_intrq_oe    (o_intrq_oe)
  );

  assign o_selected    = (i_dev_bit == drive_reg);
  assign o_drive_num   = drive_reg;
  assign o_dmarq       = dmarq_reg;
  assign o_rd_done     = rd_done_reg;
  assign o_wr_done     = wr_done_reg;
  assign o_wr_data     = wr_data_reg;
  assign o_wr_wide     = wr_wide_reg;
  assign o_dma_rd_done = dma_rd_reg;
  assign o_dma_wr_done = dma_wr_reg;
  assign o_host_reset  = host_reset;
  assign o_irq_pending = irq_pending;

  property p_rd_done;
    @(posedge i_mclk) disable iff (!i_resetn)
    (rise[`SYNC_DIOR] && !grant) |=> o_rd_done && !o_dma_rd_done;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read completion missed");
  property p_iordy;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_iordy_oe |-> (i_busy && i_cs_active && o_iordy_out == `PIN_LOW);
  endproperty
  a_iordy: assert property (p_iordy) else $error("ready held without cause");
  property p_iordy_rel;
    @(posedge i_mclk) disable iff (!i_resetn)
    (!i_busy || !access) |-> !o_iordy_oe;
  endproperty
  a_iordy_rel: assert property (p_iordy_rel) else $error("ready not released");
  property p_strap;
    @(posedge i_mclk) disable iff (!i_resetn)
    strap_done_reg && $past(strap_done_reg) |-> $stable(o_drive_num);
  endproperty
  a_strap: assert property (p_strap) else $error("drive number moved");
  property p_dmarq;
    @(posedge i_mclk) disable iff (!i_resetn)
    i_dma_ready |=> o_dmarq;
  endproperty
  a_dmarq: assert property (p_dmarq) else $error("dma request dropped");
  property p_dma_dir;
    @(posedge i_mclk) disable iff (!i_resetn)
    (rise[`SYNC_DIOW] && grant) |=> o_dma_wr_done && !o_wr_done;
  endproperty
  a_dma_dir: assert property (p_dma_dir) else $error("dma write not seen");
  property p_wr_data;
    @(posedge i_mclk) disable iff (!i_resetn)
    rise[`SYNC_DIOW] |=> o_wr_data == lane_mask($past(wr_hold_reg), $past(wr_wide_hold_reg));
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data wrong");
  property p_narrow;
    @(posedge i_mclk) disable iff (!i_resetn)
    !rd_wide_reg |-> o_dd[`DD_W-1:`DD_LO_W] == `DD_HI_ZERO;
  endproperty
  a_narrow: assert property (p_narrow) else $error("high byte on narrow read");
  property p_iocs16;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_iocs16_oe |-> (i_addr_data && i_word_ready && o_iocs16_out == `PIN_LOW);
  endproperty
  a_iocs16: assert property (p_iocs16) else $error("wide port flagged wrongly");
  property p_cmd_clear;
    @(posedge i_mclk) disable iff (!i_resetn)
    (o_wr_done && i_addr_command && !i_irq_event && !i_block_start) |=> !o_irq_pending;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command write kept intrq");
  property p_sync;
    @(posedge i_mclk) disable iff (!i_resetn)
    $fell(i_dior_n) |-> !rise[`SYNC_DIOR];
  endproperty
  a_sync: assert property (p_sync) else $error("strobe edge too early");
endmodule : ide_device_host_signal_logic

//--- design/ide_host_signal_map.svh
// Purpose: named constants of the host signal logic
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef IDE_HOST_SIGNAL_MAP_SVH
`define IDE_HOST_SIGNAL_MAP_SVH
`define DD_W         16
`define DD_LO_W      8
`define DD_ZERO      16'h0000
`define DD_HI_ZERO   8'h00
`define SYNC_W       4
`define SYNC_DIOR    0
`define SYNC_DIOW    1
`define SYNC_GRANT   2
`define SYNC_HRST    3
`define SYNC_IDLE    4'hf
`define CMD_W        3
`define BIT_CLR      1'b0
`define BIT_SET      1'b1
`define DRIVE_0      1'b0
`define PIN_LOW      1'b0
`endif

//--- design/ide_host_signal_pkg.sv
// Purpose: shared types of the host signal logic
// Assumes: ide_host_signal_map.svh holds the widths
// Notes:   command classes steer the first-block interrupt
`include "ide_host_signal_map.svh"
package ide_host_signal_pkg;
  typedef logic [`DD_W-1:0]   dd_t;
  typedef logic [`SYNC_W-1:0] sync_t;
  typedef enum logic [`CMD_W-1:0]
  {
    cmd_other        = 3'h0,
    cmd_format_track = 3'h1,
    cmd_write_sector = 3'h2,
    cmd_write_buffer = 3'h3,
    cmd_write_long   = 3'h4
  } cmd_class_e;
endpackage : ide_host_signal_pkg

//--- design/intrq_ctrl.sv
// Purpose: pending interrupt, masking and clearing toward the host
// Assumes: clear and event inputs are one-cycle pulses
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/1ps
`include "ide_host_signal_map.svh"
module intrq_ctrl
(
  input  wire logic                             i_mclk,
  input  wire logic                             i_resetn,
  input  wire logic                             i_irq_event,
  input  wire logic                             i_block_start,
  input  wire logic                             i_first_block,
  input  wire ide_host_signal_pkg::cmd_class_e  i_cmd_class,
  input  wire logic                             i_clear,
  input  wire logic                             i_selected,
  input  wire logic                             i_nien,
  output logic                                  o_pending,
  output logic                                  o_intrq_out,
  output logic                                  o_intrq_oe
);
  import ide_host_signal_pkg::*;
  logic pending_reg;
  logic suppress;
  logic set_now;

  // first block of these write-type commands raises no interrupt
  assign suppress = i_first_block &&
                    ((i_cmd_class == cmd_format_track) ||
                     (i_cmd_class == cmd_write_sector) ||
                     (i_cmd_class == cmd_write_buffer) ||
                     (i_cmd_class == cmd_write_long));
  assign set_now  = i_irq_event || (i_block_start && !suppress);

  // pending flag, set beats clear
  always_ff @(posedge i_mclk)
  begin
    if (!i_resetn)
      pending_reg <= `BIT_CLR;
    else if (set_now)
      pending_reg <= `BIT_SET;
    else if (i_clear)
      pending_reg <= `BIT_CLR;
  end

  // pin drives only when selected and unmasked
  assign o_pending   = pending_reg;
  assign o_intrq_oe  = i_selected && !i_nien;
  assign o_intrq_out = pending_reg;

  property p_gate;
    @(posedge i_mclk) disable iff (!i_resetn)
    o_intrq_oe |-> (i_selected && !i_nien);
  endproperty
  a_gate: assert property (p_gate) else $error("intrq driven while masked");

  property p_float;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_nien || !i_selected) |-> !o_intrq_oe;
  endproperty
  a_float: assert property (p_float) else $error("intrq not released");

  property p_clear;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_clear && !set_now) |=> !o_intrq_out;
  endproperty
  a_clear: assert property (p_clear) else $error("intrq not cleared");

  property p_block;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_block_start && !i_first_block) |=> o_intrq_out;
  endproperty
  a_block: assert property (p_block) else $error("block start lost");

  property p_first;
    @(posedge i_mclk) disable iff (!i_resetn)
    (i_block_start && i_first_block && i_cmd_class == cmd_write_long
     && !i_irq_event && !o_pending) |=> !o_intrq_out;
  endproperty
  a_first: assert property (p_first) else $error("first block raised intrq");
endmodule : intrq_ctrl

//--- verif/host_adapter_model.sv
// Purpose: host adapter side of the drive connector
// Assumes: strobes move just after a rising edge of i_mclk
// Notes:   ready line has a pull-up; a released data bus shows inverted data
`timescale 1ns/1ps
module host_adapter_model
(
  input  wire logic                      i_mclk,
  input  wire logic                      i_iordy_oe,
  input  wire ide_host_signal_pkg::dd_t  i_dev_dd,
  input  wire logic                      i_dev_dd_oe,
  output logic                           o_dior_n,
  output logic                           o_diow_n,
  output logic                           o_grant_n,
  output logic                           o_host_reset_n,
  output ide_host_signal_pkg::dd_t       o_dd,
  output logic                           o_iordy_wire
);
  import ide_host_signal_pkg::*;
  dd_t host_dd;
  // bus and ready line resolution
  assign o_dd         = i_dev_dd_oe ? i_dev_dd : host_dd;
  assign o_iordy_wire = i_iordy_oe ? 1'b0 : 1'b1;
  // idle pins at time zero
  initial
  begin
    o_dior_n       = 1'b1;
    o_diow_n       = 1'b1;
    o_grant_n      = 1'b1;
    o_host_reset_n = 1'b1;
    host_dd        = 16'h5a5a;
  end
  // strap-like pins: grant and host reset
  task automatic set_pins(input logic grant_n, input logic rst_n);
    @(posedge i_mclk);
    o_grant_n      <= grant_n;
    o_host_reset_n <= rst_n;
  endtask : set_pins
  // one strobe cycle; waits while the drive stretches it
  task automatic access(input logic rd, input dd_t wdata, output dd_t rdata);
    int n;
    @(posedge i_mclk);
    host_dd <= rd ? host_dd : wdata;
    @(posedge i_mclk);
    if (rd)
      o_dior_n <= 1'b0;
    else
      o_diow_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
    n = 0;
    while (o_iordy_wire === 1'b0 && n < 200)
    begin
      @(posedge i_mclk);
      n++;
    end
    repeat (3) @(posedge i_mclk);
    rdata = o_dd;
    o_dior_n <= 1'b1;
    o_diow_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    host_dd <= ~host_dd;
    repeat (4) @(posedge i_mclk);
  endtask : access
endmodule : host_adapter_model

//--- verif/tb_ide_device_host_signal_logic.sv
// Purpose: self-checking bench of the drive-side host signal logic
// Assumes: host adapter model drives the strobes, grant and reset pin
// Notes:   table covers the iocs16 and intrq enables; sequences follow
`timescale 1ns/1ps
module tb_ide_device_host_signal_logic;
  import ide_host_signal_pkg::*;
  typedef struct packed {logic cs, ad, wr, nien, dev, iocs_exp, ioe_exp;} row_s;
  logic i_mclk, i_resetn, dior_n, diow_n, grant_n, hrst_n, cable_sel, iordy_wire;
  logic i_cs_active, i_addr_data, i_addr_status, i_addr_command, i_busy;
  logic i_word_ready, i_dma_ready, i_dev_bit, i_nien, i_srst, i_irq_event;
  logic i_block_start, i_first_block;
  cmd_class_e i_cmd_class;
  dd_t bus_dd, o_dd, i_rd_data, o_wr_data, got;
  logic o_dd_oe, o_iordy_out, o_iordy_oe, o_iocs16_out, o_iocs16_oe, o_intrq_out;
  logic o_intrq_oe, o_dmarq, o_drive_num, o_selected, o_rd_done, o_wr_done, o_wr_wide;
  logic o_dma_rd_done, o_dma_wr_done, o_host_reset, o_irq_pending;
  int num_errors, tests_run, cycles, rd_cnt, wr_cnt, drd_cnt, dwr_cnt;
  row_s rows [5] = '{7'b1110011, 7'b0110001, 7'b1011000, 7'b1100100, 7'b1111110};
  ide_device_host_signal_logic i_ide_device_host_signal_logic (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .i_host_reset_n(hrst_n), .i_dior_n(dior_n), .i_diow_n(diow_n),
    .i_dma_grant_n(grant_n), .i_cable_sel(cable_sel), .i_dd(bus_dd), .o_dd(o_dd),
    .o_dd_oe(o_dd_oe), .o_iordy_out(o_iordy_out), .o_iordy_oe(o_iordy_oe),
    .o_iocs16_out(o_iocs16_out), .o_iocs16_oe(o_iocs16_oe), .o_intrq_out(o_intrq_out),
    .o_intrq_oe(o_intrq_oe), .o_dmarq(o_dmarq), .i_cs_active(i_cs_active),
    .i_addr_data(i_addr_data), .i_addr_status(i_addr_status),
    .i_addr_command(i_addr_command), .i_rd_data(i_rd_data), .i_busy(i_busy),
    .i_word_ready(i_word_ready), .i_dma_ready(i_dma_ready), .i_dev_bit(i_dev_bit),
    .i_nien(i_nien), .i_srst(i_srst), .i_irq_event(i_irq_event),
    .i_block_start(i_block_start), .i_first_block(i_first_block),
    .i_cmd_class(i_cmd_class), .o_drive_num(o_drive_num), .o_selected(o_selected),
    .o_rd_done(o_rd_done), .o_wr_done(o_wr_done), .o_wr_data(o_wr_data),
    .o_wr_wide(o_wr_wide), .o_dma_rd_done(o_dma_rd_done), .o_dma_wr_done(o_dma_wr_done),
    .o_host_reset(o_host_reset), .o_irq_pending(o_irq_pending));
  host_adapter_model i_host_adapter_model (.i_mclk(i_mclk), .i_iordy_oe(o_iordy_oe),
    .i_dev_dd(o_dd), .i_dev_dd_oe(o_dd_oe), .o_dior_n(dior_n), .o_diow_n(diow_n),
    .o_grant_n(grant_n), .o_host_reset_n(hrst_n), .o_dd(bus_dd), .o_iordy_wire(iordy_wire));
  // 20 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // done pulse counters and hang limit
  always @(posedge i_mclk)
  begin
    rd_cnt  += (o_rd_done === 1'b1);
    wr_cnt  += (o_wr_done === 1'b1);
    drd_cnt += (o_dma_rd_done === 1'b1);
    dwr_cnt += (o_dma_wr_done === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  // compare seen against expected
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic final_report();
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick
  // one-cycle interrupt source pulse
  task automatic pulse(input logic blk, input logic first, input cmd_class_e c);
    @(posedge i_mclk);
    i_irq_event   <= ~blk;
    i_block_start <= blk;
    i_first_block <= first;
    i_cmd_class   <= c;
    @(posedge i_mclk);
    i_irq_event   <= 1'b0;
    i_block_start <= 1'b0;
    tick(2);
  endtask : pulse
  task automatic soft_clear();
    @(posedge i_mclk);
    i_srst <= 1'b1;
    @(posedge i_mclk);
    i_srst <= 1'b0;
    tick(2);
  endtask : soft_clear
  // main sequence
  initial
  begin
    {i_resetn, cable_sel, i_cs_active, i_addr_data, i_addr_status, i_addr_command} = '0;
    {i_busy, i_word_ready, i_dma_ready, i_dev_bit, i_nien, i_srst, i_irq_event} = '0;
    {i_block_start, i_first_block, num_errors, tests_run, cycles} = '0;
    {rd_cnt, wr_cnt, drd_cnt, dwr_cnt} = '0;
    i_cmd_class = cmd_other;
    i_rd_data   = 16'h0000;
    tick(4);
    i_resetn <= 1'b1;
    tick(3);
    check("drive_num", o_drive_num, 1'b0);
    check("dmarq", o_dmarq, 1'b0);
    check("intrq_out", o_intrq_out, 1'b0);
    check("iordy_out", o_iordy_out, 1'b0);
    check("iocs16_out", o_iocs16_out, 1'b0);
    foreach (rows[k])
    begin
      @(posedge i_mclk);
      {i_cs_active, i_addr_data, i_word_ready, i_nien, i_dev_bit} <= rows[k][6:2];
      tick(1);
      check("iocs16_oe", o_iocs16_oe, rows[k].iocs_exp);
      check("intrq_oe", o_intrq_oe, rows[k].ioe_exp);
    end
    {i_cs_active, i_addr_data, i_word_ready, i_nien, i_dev_bit} <= 5'b11100;
    i_rd_data <= 16'ha5c3;
    i_host_adapter_model.access(1'b1, 16'h0000, got);
    check("wide read", got, 16'ha5c3);
    check("rd_done", rd_cnt, 1);
    check("dd_oe idle", o_dd_oe, 1'b0);
    i_host_adapter_model.access(1'b0, 16'hbeef, got);
    check("wide write", o_wr_data, 16'hbeef);
    check("wr_wide", o_wr_wide, 1'b1);
    i_addr_data <= 1'b0;
    i_host_adapter_model.access(1'b1, 16'h0000, got);
    check("narrow read", got, 16'h00c3);
    i_host_adapter_model.access(1'b0, 16'h1234, got);
    check("narrow write", o_wr_data, 16'h0034);
    check("wr_done", wr_cnt, 2);
    i_busy <= 1'b1;
    fork
      i_host_adapter_model.access(1'b1, 16'h0000, got);
      begin
        tick(12);
        check("iordy held", iordy_wire, 1'b0);
        i_busy <= 1'b0;
      end
    join
    check("iordy released", o_iordy_oe, 1'b0);
    check("iordy pulled", iordy_wire, 1'b1);
    i_dma_ready <= 1'b1;
    tick(2);
    check("dmarq up", o_dmarq, 1'b1);
    i_host_adapter_model.set_pins(1'b0, 1'b1);
    i_host_adapter_model.access(1'b1, 16'h0000, got);
    i_host_adapter_model.access(1'b0, 16'h0f0f, got);
    check("dma rd", drd_cnt, 1);
    check("dma wr", dwr_cnt, 1);
    check("pio rd", rd_cnt, 3);
    i_host_adapter_model.set_pins(1'b1, 1'b1);
    i_dma_ready <= 1'b0;
    tick(2);
    check("dmarq down", o_dmarq, 1'b0);
    pulse(1'b0, 1'b0, cmd_other);
    check("intrq set", o_intrq_out & o_intrq_oe, 1'b1);
    i_addr_status <= 1'b1;
    i_host_adapter_model.access(1'b1, 16'h0000, got);
    check("status read clear", o_irq_pending, 1'b0);
    i_addr_status <= 1'b0;
    pulse(1'b0, 1'b0, cmd_other);
    i_addr_command <= 1'b1;
    i_host_adapter_model.access(1'b0, 16'h0020, got);
    check("command write clear", o_irq_pending, 1'b0);
    i_addr_command <= 1'b0;
    pulse(1'b0, 1'b0, cmd_other);
    soft_clear();
    check("srst clear", o_irq_pending, 1'b0);
    pulse(1'b0, 1'b0, cmd_other);
    i_host_adapter_model.set_pins(1'b1, 1'b0);
    tick(5);
    check("host reset seen", o_host_reset, 1'b1);
    check("reset pin clear", o_irq_pending, 1'b0);
    i_host_adapter_model.set_pins(1'b1, 1'b1);
    tick(4);
    for (int c = 0; c < 5; c++)
    begin
      pulse(1'b1, 1'b1, cmd_class_e'(c));
      check("first block irq", o_irq_pending, c == 0);
      soft_clear();
      pulse(1'b1, 1'b0, cmd_class_e'(c));
      check("later block irq", o_irq_pending, 1'b1);
      soft_clear();
    end
    cable_sel <= 1'b1;
    i_resetn  <= 1'b0;
    tick(4);
    i_resetn <= 1'b1;
    i_dev_bit <= 1'b1;
    tick(3);
    check("drive_num one", o_drive_num, 1'b1);
    check("selected", o_selected, 1'b1);
    final_report();
  end
endmodule : tb_ide_device_host_signal_logic
